// >>> hw/cic_pkg.sv
// Package: register map, fields, reset values and widths of the interrupt controller
package cic_pkg;
  localparam int SRC_MAX = 32;
  localparam int CASCADE_BIT = 31;
  localparam int REG_AW = 6;
  // Word offsets of the register map
  localparam logic [5:0] OFF_STATUS = 6'h00;
  localparam logic [5:0] OFF_PENDING = 6'h01;
  localparam logic [5:0] OFF_ENABLE = 6'h02;
  localparam logic [5:0] OFF_ACK = 6'h03;
  localparam logic [5:0] OFF_SET_EN = 6'h04;
  localparam logic [5:0] OFF_CLR_EN = 6'h05;
  localparam logic [5:0] OFF_VECTOR = 6'h06;
  localparam logic [5:0] OFF_MASTER = 6'h07;
  localparam logic [5:0] OFF_MODE = 6'h08;
  localparam logic [5:0] OFF_VADDR = 6'h20;
  // Master control fields
  localparam int MC_ENABLE_BIT = 0;
  localparam int MC_LOCK_BIT = 1;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [31:0] NO_VECTOR = 32'hFFFF_FFFF;
  // Source kind encodings
  localparam logic KIND_LEVEL = 1'b0;
  localparam logic KIND_EDGE = 1'b1;
endpackage

// >>> hw/cic_link_if.sv
// Interface: request link between a lower controller and its consumer
`timescale 1ns/1ps
interface cic_link_if;
  logic irq;
  logic [31:0] vec_addr;
  logic [31:0] proc_ack;
  logic ack_valid;
  modport dev
  (
    output irq,
    output vec_addr,
    input proc_ack,
    input ack_valid
  );
  modport host
  (
    input irq,
    input vec_addr,
    output proc_ack,
    output ack_valid
  );
endinterface

// >>> hw/cic_ctrl.sv
// Device end: cascadable interrupt controller with software register port
//
// Summary of operation
// - Upstream source 31 carries cascade request
// - Primary setting only with cascade enabled
// - Only source 31 is the cascade input
// - Primary serves sources 0-30 before 31
// - Fast cascade adds vector in, ack out
// - Source 31 sensitivity matches lower output
// - Fast support everywhere if anywhere
// - Hardware sources low, software sources above
// - Per-source edge or level, chosen polarity
// - Unlocked: status write raises request
// - Lock bit write-once, enables hardware inputs
// - OR enabled pending, gate by master
// - Everything disabled after reset
// - Vector index: lowest enabled active, else ones
// - Status shows active; pending shows enabled
// - Fast mode: vector address readable
// - Ack write one clears pending
// - Disabling does not clear pending
// - Fast ack port clears ack bit
// - Persisting source re-raises after ack
// - Master enable zero masks output anytime
// - Set/clear enable touch only written bits
// - Master control: enable bit0, lock bit1
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module cic_ctrl #(
  parameter int HW_COUNT = 32,
  parameter int SW_COUNT = 0,
  parameter logic [31:0] SOURCE_TYPE = 32'hFFFF_FFFF,
  parameter logic [31:0] EDGE_POLARITY = 32'hFFFF_FFFF,
  parameter logic [31:0] LEVEL_POLARITY = 32'hFFFF_FFFF,
  parameter bit CASCADE_EN = 1'b0,
  parameter bit CASCADE_PRIMARY = 1'b0,
  parameter bit HAS_FAST = 1'b0
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [31:0] intr_in,
  input wire logic [31:0] casc_vec_in,
  output logic casc_ack_out,
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  cic_link_if.dev link
);
  localparam int NSRC = HW_COUNT + SW_COUNT;
  localparam logic [31:0] SRC_MASK = (NSRC >= 32) ? 32'hFFFF_FFFF : ((32'h1 << NSRC) - 32'h1);
  localparam logic [31:0] HW_MASK = (HW_COUNT >= 32) ? 32'hFFFF_FFFF
                                                      : ((32'h1 << HW_COUNT) - 32'h1);
  localparam logic [31:0] SW_MASK = SRC_MASK & ~HW_MASK;
  // Illegal primary-without-cascade combination stops elaboration
  if (CASCADE_PRIMARY && !CASCADE_EN)
  begin : g_drc
    $error("primary cascade setting needs cascade mode");
  end

  logic [31:0] sync1_q, sync2_q, prev_q;
  logic [31:0] status_q, status_d, enable_q, enable_d, mode_q;
  logic master_en_q, lock_q, irq_q, ack_out_q;
  logic [31:0] vaddr_q [0:31];
  logic [31:0] vec_addr_q, rdata_d;
  logic [31:0] valid_hw, hw_hit, active_en, ack_bits, proc_clear;
  logic [31:0] vec_index;
  logic [31:0] sel_addr;
  logic have_vec;

  // Two-stage synchroniser, then edge/level qualification per source
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_q <= cic_pkg::RST_WORD;
      sync2_q <= cic_pkg::RST_WORD;
      prev_q <= cic_pkg::RST_WORD;
    end
    else
    begin
      sync1_q <= intr_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // Source 31 on a cascaded part is just the lower irq, qualified like any pin
  genvar gi;
  for (gi = 0; gi < 32; gi++)
  begin : g_src
    assign valid_hw[gi] = (SOURCE_TYPE[gi] == cic_pkg::KIND_EDGE)
      ? (EDGE_POLARITY[gi] ? (sync2_q[gi] & ~prev_q[gi]) : (~sync2_q[gi] & prev_q[gi]))
      : (sync2_q[gi] == LEVEL_POLARITY[gi]);
  end

  // Hardware inputs count only once locked
  assign hw_hit = lock_q ? (valid_hw & HW_MASK) : 32'h0000_0000;
  assign ack_bits = (reg_wr && reg_addr == cic_pkg::OFF_ACK) ? (reg_wdata & SRC_MASK)
                                                              : 32'h0000_0000;
  assign proc_clear = (HAS_FAST && link.ack_valid) ? (link.proc_ack & mode_q & SRC_MASK)
                                                    : 32'h0000_0000;

  // Set beats clear, so a level still present or a new edge re-raises
  always_comb
  begin
    status_d = status_q & ~ack_bits & ~proc_clear;
    if (reg_wr && reg_addr == cic_pkg::OFF_STATUS)
    begin
      status_d = status_d | (reg_wdata & (lock_q ? SW_MASK : SRC_MASK));
    end
    status_d = status_d | hw_hit;
  end

  // Enable register with atomic set and clear locations
  always_comb
  begin
    enable_d = enable_q;
    if (reg_wr && reg_addr == cic_pkg::OFF_ENABLE)
    begin
      enable_d = reg_wdata & SRC_MASK;
    end
    else if (reg_wr && reg_addr == cic_pkg::OFF_SET_EN)
    begin
      enable_d = enable_q | (reg_wdata & SRC_MASK);
    end
    else if (reg_wr && reg_addr == cic_pkg::OFF_CLR_EN)
    begin
      enable_d = enable_q & ~reg_wdata;
    end
  end

  assign active_en = status_q & enable_q;

  // Lowest index wins; sources 0-30 precede the cascade bit naturally
  always_comb
  begin
    vec_index = cic_pkg::NO_VECTOR;
    have_vec = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      if (active_en[i])
      begin
        vec_index = 32'(i);
        have_vec = 1'b1;
      end
    end
  end
  assign sel_addr = have_vec ? ((CASCADE_EN && vec_index[4:0] == 5'd31 && HAS_FAST)
                                ? casc_vec_in : vaddr_q[vec_index[4:0]])
                             : cic_pkg::RST_WORD;

  // Read mux: unmapped words read zero
  always_comb
  begin
    if (reg_addr == cic_pkg::OFF_STATUS)
      rdata_d = status_q;
    else if (reg_addr == cic_pkg::OFF_PENDING)
      rdata_d = active_en;
    else if (reg_addr == cic_pkg::OFF_ENABLE)
      rdata_d = enable_q;
    else if (reg_addr == cic_pkg::OFF_VECTOR)
      rdata_d = vec_index;
    else if (reg_addr == cic_pkg::OFF_MASTER)
      rdata_d = {30'h0, lock_q, master_en_q};
    else if (reg_addr == cic_pkg::OFF_MODE && HAS_FAST)
      rdata_d = mode_q;
    else if (reg_addr >= cic_pkg::OFF_VADDR && HAS_FAST)
      rdata_d = vaddr_q[reg_addr[4:0]];
    else
      rdata_d = cic_pkg::RST_WORD;
  end

  // Register state; everything starts disabled
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status_q <= cic_pkg::RST_WORD;
      enable_q <= cic_pkg::RST_WORD;
      mode_q <= cic_pkg::RST_WORD;
      master_en_q <= 1'b0;
      lock_q <= 1'b0;
      reg_rdata <= cic_pkg::RST_WORD;
    end
    else
    begin
      status_q <= status_d;
      enable_q <= enable_d;
      if (reg_rd)
        reg_rdata <= rdata_d;
      else
        reg_rdata <= cic_pkg::RST_WORD;
      if (reg_wr && reg_addr == cic_pkg::OFF_MASTER)
      begin
        master_en_q <= reg_wdata[cic_pkg::MC_ENABLE_BIT];
        lock_q <= lock_q | reg_wdata[cic_pkg::MC_LOCK_BIT];
      end
      if (reg_wr && reg_addr == cic_pkg::OFF_MODE && HAS_FAST)
        mode_q <= reg_wdata & SRC_MASK;
    end
  end

  // Vector address storage, kept without reset values beyond zero
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int k = 0; k < 32; k++)
        vaddr_q[k] <= cic_pkg::RST_WORD;
    end
    else if (HAS_FAST && reg_wr && reg_addr >= cic_pkg::OFF_VADDR
             && {1'b0, reg_addr[4:0]} < 6'(NSRC)) // Six bits so 32 sources still fit
    begin
      vaddr_q[reg_addr[4:0]] <= reg_wdata;
    end
  end

  // Request output, same gating toward a processor or an upstream controller
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_q <= 1'b0;
      vec_addr_q <= cic_pkg::RST_WORD;
      ack_out_q <= 1'b0;
    end
    else
    begin
      irq_q <= master_en_q & (|active_en);
      vec_addr_q <= sel_addr;
      // Pass the processor ack on to the lower part for the cascade bit
      ack_out_q <= HAS_FAST && CASCADE_EN && link.ack_valid
                   && link.proc_ack[cic_pkg::CASCADE_BIT];
    end
  end

  assign link.irq = irq_q;
  assign link.vec_addr = vec_addr_q;
  assign casc_ack_out = ack_out_q;
endmodule

// >>> hw/cic_cpu.sv
// Host end: processor-side consumer that acknowledges fast requests
`timescale 1ns/1ps
module cic_cpu #(
  parameter bit HAS_FAST = 1'b0
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  cic_link_if.host link,
  input wire logic [31:0] ack_mask,
  input wire logic ack_go,
  output logic irq_seen,
  output logic [31:0] vec_seen
);
  logic [31:0] ack_q;
  logic valid_q;

  // Sample request and vector; fire one ack pulse on demand
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_seen <= 1'b0;
      vec_seen <= cic_pkg::RST_WORD;
      ack_q <= cic_pkg::RST_WORD;
      valid_q <= 1'b0;
    end
    else
    begin
      irq_seen <= link.irq;
      vec_seen <= link.vec_addr;
      valid_q <= HAS_FAST && ack_go;
      ack_q <= ack_go ? ack_mask : cic_pkg::RST_WORD;
    end
  end
  assign link.proc_ack = ack_q;
  assign link.ack_valid = valid_q;
endmodule

// >>> sim/cic_link_sva.sv
// Checker: link and register port relations of the interrupt controller
`timescale 1ns/1ps
module cic_link_sva (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic irq,
  input wire logic [31:0] proc_ack,
  input wire logic ack_valid,
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Master-control writes and reads, and vector reads, decoded once
  wire mc_wr = reg_wr && reg_addr == cic_pkg::OFF_MASTER;
  wire mc_rd = reg_rd && reg_addr == cic_pkg::OFF_MASTER;
  wire vec_rd = reg_rd && reg_addr == cic_pkg::OFF_VECTOR;
  property p_reset_quiet;
    $rose(reset_n) |-> !irq && !ack_valid;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("irq up after reset");
  property p_master_off;
    mc_wr && !reg_wdata[0] |-> ##2 !irq;
  endproperty
  a_master_off: assert property (p_master_off) else $error("irq not masked");
  property p_ack_pulse;
    ack_valid |=> !ack_valid;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
  property p_ack_mask;
    ack_valid |-> proc_ack != 32'h0000_0000;
  endproperty
  a_ack_mask: assert property (p_ack_mask) else $error("empty ack pattern");
  // Pins never drop a request: only a write or an ack can
  property p_no_self_clear;
    $fell(irq) |-> $past(reg_wr, 2) || $past(ack_valid, 2);
  endproperty
  a_no_self_clear: assert property (p_no_self_clear) else $error("irq fell uncaused");
  property p_master_read;
    $past(mc_rd) |-> reg_rdata[31:2] == 30'h0000_0000;
  endproperty
  a_master_read: assert property (p_master_read) else $error("master high bits set");
  property p_vector_form;
    $past(vec_rd) |-> reg_rdata < 32'h0000_0020 || reg_rdata == cic_pkg::NO_VECTOR;
  endproperty
  a_vector_form: assert property (p_vector_form) else $error("bad vector index");
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  c_irq: cover property ($rose(irq));
  c_ack: cover property (ack_valid ##2 !irq);
  c_vec: cover property (vec_rd);
endmodule

// >>> sim/cascadable_interrupt_controller_tb_top.sv
// Testbench: controller and processor end joined by the link
`timescale 1ns/1ps
module cascadable_interrupt_controller_tb_top;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] intr_in = 32'h0000_00CA;
  logic [5:0] reg_addr = 6'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] ack_mask = 32'h0000_0000;
  logic ack_go = 1'b0;
  logic rd_pend = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] d;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] casc_vec = 32'h0000_0000;
  logic casc_ack;
  logic irq_seen;
  logic [31:0] vec_seen;
  localparam int HW_N = 8;
  localparam int SW_N = 4;
  localparam bit FAST = 1'b1; // Same fast setting on both ends
  cic_link_if link ();
  // Bits 0-3 edge (0,2 rise; 1,3 fall), 4-5 high level, 6-7 low level
  cic_ctrl #(.HW_COUNT(HW_N), .SW_COUNT(SW_N), .SOURCE_TYPE(32'h0000_000F),
    .EDGE_POLARITY(32'h0000_0005), .LEVEL_POLARITY(32'h0000_0030), .HAS_FAST(FAST))
  i_cic_ctrl (.ref_clk(ref_clk), .reset_n(reset_n), .intr_in(intr_in),
    .casc_vec_in(casc_vec), .casc_ack_out(casc_ack), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link(link));
  cic_cpu #(.HAS_FAST(FAST)) i_cic_cpu (.ref_clk(ref_clk), .reset_n(reset_n),
    .link(link), .ack_mask(ack_mask), .ack_go(ack_go), .irq_seen(irq_seen),
    .vec_seen(vec_seen));
  cic_link_sva i_cic_link_sva (.ref_clk(ref_clk), .reset_n(reset_n), .irq(link.irq),
    .proc_ack(link.proc_ack), .ack_valid(link.ack_valid), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  always #12.5 ref_clk = ~ref_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read note goes on the queue; the watcher compares the slot after
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask
  // Four edges: the processor end copies irq one cycle behind the link
  task automatic irq_is(input logic e);
    repeat (4) @(posedge ref_clk);
    check({31'h0, link.irq}, {31'h0, e}, "irq");
    check({31'h0, irq_seen}, {31'h0, e}, "irq_seen");
  endtask
  function automatic logic [31:0] low_idx(input logic [31:0] v);
    low_idx = cic_pkg::NO_VECTOR;
    for (int i = 31; i >= 0; i--)
      if (v[i])
        low_idx = 32'(i);
  endfunction
  // Watcher: read data stand only in the cycle after the strobe
  always @(posedge ref_clk)
  begin
    if (rd_pend)
      check(reg_rdata, exp_q.pop_front(), "rdata");
    rd_pend <= reg_rd;
    cycles++;
    if (cycles == 6000)
    begin
      bad_count++;
      complete_run();
    end
  end
  initial
  begin
    void'($urandom(32'h27efc268));
    casc_vec <= $urandom;
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(cic_pkg::OFF_MASTER, 32'h0000_0000);
    rd(cic_pkg::OFF_ENABLE, 32'h0000_0000);
    rd(cic_pkg::OFF_VECTOR, cic_pkg::NO_VECTOR);
    wr(cic_pkg::OFF_ENABLE, 32'hFFFF_FFFF);
    rd(cic_pkg::OFF_ENABLE, 32'h0000_0FFF);
    intr_in <= 32'h0000_0095;
    wr(cic_pkg::OFF_STATUS, 32'h0000_0A04);
    rd(cic_pkg::OFF_STATUS, 32'h0000_0A04);
    intr_in <= 32'h0000_00CA;
    wr(cic_pkg::OFF_MASTER, 32'h0000_0001);
    irq_is(1'b1);
    wr(cic_pkg::OFF_CLR_EN, 32'h0000_0004);
    rd(cic_pkg::OFF_ENABLE, 32'h0000_0FFB);
    rd(cic_pkg::OFF_PENDING, 32'h0000_0A00);
    rd(cic_pkg::OFF_VECTOR, 32'h0000_0009);
    wr(cic_pkg::OFF_SET_EN, 32'h0000_0004);
    wr(cic_pkg::OFF_MASTER, 32'h0000_0000);
    irq_is(1'b0);
    // Random self-test patterns, lowest enabled bit reported
    repeat (4)
    begin
      d = $urandom & 32'h0000_0FFF;
      wr(cic_pkg::OFF_ACK, 32'h0000_0FFF);
      wr(cic_pkg::OFF_STATUS, d);
      rd(cic_pkg::OFF_STATUS, d);
      rd(cic_pkg::OFF_VECTOR, low_idx(d));
    end
    wr(cic_pkg::OFF_ACK, 32'h0000_0FFF);
    wr(cic_pkg::OFF_MASTER, 32'h0000_0003);
    wr(cic_pkg::OFF_MASTER, 32'h0000_0001);
    rd(cic_pkg::OFF_MASTER, 32'h0000_0003);
    wr(cic_pkg::OFF_STATUS, 32'h0000_01FF);
    rd(cic_pkg::OFF_STATUS, 32'h0000_0100);
    wr(cic_pkg::OFF_ACK, 32'h0000_0100);
    rd(cic_pkg::OFF_STATUS, 32'h0000_0000);
    // Each pin kind: only the configured edge or level counts
    intr_in <= 32'h0000_0095;
    repeat (5) @(posedge ref_clk);
    rd(cic_pkg::OFF_STATUS, 32'h0000_005F);
    intr_in <= 32'h0000_00DA;
    repeat (5) @(posedge ref_clk);
    wr(cic_pkg::OFF_ACK, 32'h0000_00FF);
    rd(cic_pkg::OFF_STATUS, 32'h0000_0010);
    intr_in <= 32'h0000_00CA;
    repeat (3) @(posedge ref_clk);
    wr(cic_pkg::OFF_ACK, 32'h0000_0010);
    irq_is(1'b0);
    // Fast mode: stored address and ack over the link
    d = $urandom;
    wr(cic_pkg::OFF_VADDR + 6'h08, d);
    rd(cic_pkg::OFF_VADDR + 6'h08, d);
    wr(cic_pkg::OFF_MODE, 32'h0000_0100);
    rd(cic_pkg::OFF_MODE, 32'h0000_0100);
    wr(cic_pkg::OFF_STATUS, 32'h0000_0100);
    irq_is(1'b1);
    check(vec_seen, d, "vec_seen");
    @(posedge ref_clk);
    ack_mask <= 32'h0000_0100;
    ack_go <= 1'b1;
    @(posedge ref_clk);
    ack_go <= 1'b0;
    irq_is(1'b0);
    rd(cic_pkg::OFF_STATUS, 32'h0000_0000);
    repeat (3) @(posedge ref_clk);
    check({31'h0, casc_ack}, 32'h0000_0000, "casc_ack");
    complete_run();
  end
endmodule
